//--- design/scrc_core.sv
// Purpose: Shutter delay and reset/control registers of the sensor core.
// Assumes: Frame start and geometry change strobes come from logic on i_clk_sys.
// Notes: Only the shutter delay is frame synchronised; the control word acts at once.
`timescale 1ns/100ps
// Contract
// - Shutter delay shortens integration by mode.
// - Delay beyond row time yields no image.
// - Hold bit keeps frame-synced updates pending.
// - Hold cleared: pending updates at next frame.
// - Default slave addresses are BA and BB.
// - Address select write ignored during standby pin.
// - Bad frame forces restart when enabled.
// - Show-bad bit chooses good or all frames.
// - First frame after geometry change is bad.
// - Policy field sets standby pin response.
// - Processor reset bit holds the processor.
// - Output disable puts pixel pins high-Z.
// - Output disable acts together with bit 6.
// - Standby bit enters low-power state.
// - Restart bit truncates frame, reads zero.
module scrc_core #(
    parameter int ROW_W = 16
) (
    input wire logic i_clk_sys,
    input wire logic i_sys_rst,
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_sda_out,
    output logic o_sda_oe,
    input wire logic i_standby_pin,
    input wire logic i_frame_start,
    input wire logic i_geom_change,
    input wire logic i_dual_adc,
    input wire logic [ROW_W-1:0] i_row_time,
    output logic [scrc_pkg::SHDLY_W:0] o_integ_cut_half,
    output logic o_no_image,
    output logic o_sync_update,
    output logic o_frame_out_en,
    output logic o_frame_bad,
    output logic o_restart,
    output logic o_proc_rst,
    output logic o_low_power,
    output logic o_pix_oe,
    output logic o_addr_alt
);
    logic wr_v;
    scrc_pkg::scrc_wr_s wr;
    logic [7:0] rd_addr;
    logic [15:0] rd_data;
    logic sb_pin;
    logic [scrc_pkg::SHDLY_W-1:0] shdly_q, shdly_act_q;
    logic shdly_pend_q;
    logic [15:0] ctrl_q, ctrl_d;
    logic bad_pend_q, cur_bad_q;

    scrc_twi_slave u_twi (
        .i_clk_sys(i_clk_sys),
        .i_sys_rst(i_sys_rst),
        .i_scl(i_scl),
        .i_sda(i_sda),
        .o_sda_out(o_sda_out),
        .o_sda_oe(o_sda_oe),
        .i_addr_alt(ctrl_q[scrc_pkg::BIT_SADDR_SEL]),
        .o_wr_v(wr_v),
        .o_wr(wr),
        .o_rd_addr(rd_addr),
        .i_rd_data(rd_data)
    );

    scrc_sync #(.WIDTH(1)) u_sb_sync (
        .i_clk_sys(i_clk_sys),
        .i_sys_rst(i_sys_rst),
        .i_d(i_standby_pin),
        .o_q(sb_pin)
    );

    function automatic logic hits(input logic [7:0] a, input logic [7:0] r);
        hits = (a == r);
    endfunction

    wire wr_sd = wr_v & hits(wr.addr, scrc_pkg::REG_SHUTTER_DELAY);
    wire wr_ct = wr_v & hits(wr.addr, scrc_pkg::REG_CORE_RESET_CONTROL);
    wire rd_sd = hits(rd_addr, scrc_pkg::REG_SHUTTER_DELAY);
    wire rd_ct = hits(rd_addr, scrc_pkg::REG_CORE_RESET_CONTROL);

    // The restart bit is never stored, so it reads back as zero.
    assign rd_data = rd_sd ? {{(16-scrc_pkg::SHDLY_W){1'b0}}, shdly_q} :
                     rd_ct ? ctrl_q : scrc_pkg::READ_ZERO;

    wire [15:0] ct_new = wr.data & scrc_pkg::CTRL_STORE_MASK;
    wire saddr_keep = sb_pin;

    always_comb
    begin
        ctrl_d = ctrl_q;
        if (wr_ct)
        begin
            ctrl_d = ct_new;
            if (saddr_keep)
                ctrl_d[scrc_pkg::BIT_SADDR_SEL] = ctrl_q[scrc_pkg::BIT_SADDR_SEL];
        end
    end

    wire hold = ctrl_q[scrc_pkg::BIT_HOLD];
    // Pending changes wait out the hold and land only on a frame start.
    wire upd = i_frame_start & ~hold;

    wire [1:0] pol = ctrl_q[scrc_pkg::POL_HI:scrc_pkg::POL_LO];
    wire pin_full = sb_pin & ~pol[1];
    wire pin_tri = sb_pin & (pol == scrc_pkg::POL_PIN_TRI);
    wire dis_tri = ctrl_q[scrc_pkg::BIT_OUT_DIS] & ctrl_q[scrc_pkg::POL_LO];
    wire hiz = pin_full | pin_tri | dis_tri;

    wire [scrc_pkg::SHDLY_W:0] cut_half = i_dual_adc ?
        {shdly_act_q, 1'b0} : {1'b0, shdly_act_q};
    // Compared in half pixel clocks so the single-converter case needs no division.
    wire [ROW_W+1:0] row_half = {1'b0, i_row_time, 1'b0};
    wire [ROW_W+1:0] cut_ext = (ROW_W+2)'(cut_half);
    wire no_img = cut_ext > row_half;

    wire bad_d = i_frame_start ? bad_pend_q : cur_bad_q;
    wire show_bad = ctrl_q[scrc_pkg::BIT_SHOW_BAD];
    wire restart_wr = wr_ct & wr.data[scrc_pkg::BIT_RESTART];
    wire restart_bad = i_frame_start & bad_pend_q & ctrl_q[scrc_pkg::BIT_RESTART_BAD];

    always_ff @(posedge i_clk_sys)
    begin
        if (i_sys_rst)
        begin
            shdly_q <= '0;
            shdly_act_q <= '0;
            shdly_pend_q <= 1'b0;
            ctrl_q <= scrc_pkg::RESET_VALUE;
            bad_pend_q <= 1'b0;
            cur_bad_q <= 1'b0;
        end
        else
        begin
            ctrl_q <= ctrl_d;
            if (wr_sd)
                shdly_q <= wr.data[scrc_pkg::SHDLY_W-1:0];
            if (upd & shdly_pend_q)
                shdly_act_q <= shdly_q;
            // A write beside the applying frame start stays pending.
            shdly_pend_q <= wr_sd | (shdly_pend_q & ~upd);
            bad_pend_q <= i_geom_change | (bad_pend_q & ~i_frame_start);
            cur_bad_q <= bad_d;
        end
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (i_sys_rst)
        begin
            o_integ_cut_half <= '0;
            o_no_image <= 1'b0;
            o_sync_update <= 1'b0;
            o_frame_out_en <= 1'b0;
            o_frame_bad <= 1'b0;
            o_restart <= 1'b0;
            o_proc_rst <= 1'b0;
            o_low_power <= 1'b0;
            o_pix_oe <= 1'b0;
            o_addr_alt <= 1'b0;
        end
        else
        begin
            o_integ_cut_half <= cut_half;
            o_no_image <= no_img;
            o_sync_update <= upd;
            o_frame_out_en <= (show_bad | ~bad_d) & ~no_img;
            o_frame_bad <= bad_d;
            o_restart <= restart_wr | restart_bad;
            o_proc_rst <= ctrl_d[scrc_pkg::BIT_PROC_RST];
            o_low_power <= ctrl_q[scrc_pkg::BIT_STANDBY] | pin_full;
            o_pix_oe <= ~hiz;
            o_addr_alt <= ctrl_q[scrc_pkg::BIT_SADDR_SEL];
        end
    end
endmodule

//--- design/scrc_sync.sv
// Purpose: Two-flop synchroniser for levels arriving from pins.
// Assumes: Each bit is an independent level; no word coherence is kept.
// Notes: The first stage feeds only the second stage.
`timescale 1ns/100ps
module scrc_sync #(
    parameter int WIDTH = 1
) (
    input wire logic i_clk_sys,
    input wire logic i_sys_rst,
    input wire logic [WIDTH-1:0] i_d,
    output logic [WIDTH-1:0] o_q
);
    logic [WIDTH-1:0] meta_q;

    always_ff @(posedge i_clk_sys)
    begin
        if (i_sys_rst)
        begin
            meta_q <= '0;
            o_q <= '0;
        end
        else
        begin
            meta_q <= i_d;
            o_q <= meta_q;
        end
    end
endmodule

//--- design/scrc_twi_slave.sv
// Purpose: Two-wire serial slave moving 16-bit words to and from the bank.
// Assumes: Bus rate far below the system clock, so edges are seen by sampling.
// Notes: Words go high byte first; writes step the pointer, reads do not.
`timescale 1ns/100ps
module scrc_twi_slave (
    input wire logic i_clk_sys,
    input wire logic i_sys_rst,
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_sda_out,
    output logic o_sda_oe,
    input wire logic i_addr_alt,
    output logic o_wr_v,
    output scrc_pkg::scrc_wr_s o_wr,
    output logic [7:0] o_rd_addr,
    input wire logic [15:0] i_rd_data
);
    logic [1:0] pin_s;
    logic scl_p_q, sda_p_q, ack_q, hi_q, nack_q, oe_q, lead_q;
    logic [3:0] cnt_q;
    logic [7:0] sh_q, ptr_q, stash_q;
    logic [15:0] tx_q;
    scrc_pkg::scrc_tw_e st_q;

    scrc_sync #(.WIDTH(2)) u_sync (
        .i_clk_sys(i_clk_sys),
        .i_sys_rst(i_sys_rst),
        .i_d({i_scl, i_sda}),
        .o_q(pin_s)
    );

    wire scl = pin_s[1];
    wire sda = pin_s[0];
    wire start_w = scl & scl_p_q & sda_p_q & ~sda;
    wire stop_w = scl & scl_p_q & ~sda_p_q & sda;
    wire rise_w = scl & ~scl_p_q;
    wire fall_w = ~scl & scl_p_q;
    wire [6:0] my_addr = i_addr_alt ? scrc_pkg::SADDR_ALT : scrc_pkg::SADDR_DEFAULT;
    wire byte_end = fall_w & (cnt_q == scrc_pkg::BIT_LAST);
    wire ack_end = fall_w & cnt_q[3];
    wire tx_bit = tx_q[{hi_q, ~cnt_q[2:0]}];
    wire oe_d = ack_q | ((st_q == scrc_pkg::ST_RD) & ~cnt_q[3] & ~tx_bit);

    // Open drain: the line is only ever pulled low.
    assign o_sda_out = 1'b0;
    assign o_sda_oe = oe_q;
    assign o_rd_addr = ptr_q;

    always_ff @(posedge i_clk_sys)
    begin
        if (i_sys_rst)
        begin
            st_q <= scrc_pkg::ST_IDLE;
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
            ack_q <= 1'b0;
            hi_q <= 1'b1;
            nack_q <= 1'b1;
            oe_q <= 1'b0;
            lead_q <= 1'b0;
            cnt_q <= scrc_pkg::CNT_ZERO;
            sh_q <= '0;
            ptr_q <= '0;
            stash_q <= '0;
            tx_q <= '0;
            o_wr_v <= 1'b0;
            o_wr <= '0;
        end
        else
        begin
            scl_p_q <= scl;
            sda_p_q <= sda;
            oe_q <= oe_d;
            o_wr_v <= 1'b0;
            if (start_w)
            begin
                st_q <= scrc_pkg::ST_ADDR;
                cnt_q <= scrc_pkg::CNT_ZERO;
                // The clock fall that closes a start condition carries no bit.
                lead_q <= 1'b1;
                ack_q <= 1'b0;
            end
            else if (stop_w)
            begin
                st_q <= scrc_pkg::ST_IDLE;
                ack_q <= 1'b0;
            end
            else if (st_q != scrc_pkg::ST_IDLE)
            begin
                if (rise_w & ~cnt_q[3])
                    sh_q <= {sh_q[6:0], sda};
                if (rise_w & cnt_q[3])
                    nack_q <= sda;
                if (rise_w)
                    lead_q <= 1'b0;
                if (fall_w & ~lead_q)
                    cnt_q <= cnt_q[3] ? scrc_pkg::CNT_ZERO : cnt_q + scrc_pkg::CNT_STEP;
                if (byte_end)
                begin
                    unique case (st_q)
                        scrc_pkg::ST_ADDR:
                        begin
                            // A read starts low, so its address acknowledge turns it high.
                            hi_q <= ~sh_q[0];
                            if (sh_q[7:1] == my_addr)
                            begin
                                ack_q <= 1'b1;
                                st_q <= sh_q[0] ? scrc_pkg::ST_RD : scrc_pkg::ST_REG;
                                tx_q <= i_rd_data;
                            end
                            else
                                st_q <= scrc_pkg::ST_IDLE;
                        end
                        scrc_pkg::ST_REG:
                        begin
                            ptr_q <= sh_q;
                            ack_q <= 1'b1;
                            hi_q <= 1'b1;
                            st_q <= scrc_pkg::ST_WR;
                        end
                        scrc_pkg::ST_WR:
                        begin
                            ack_q <= 1'b1;
                            hi_q <= ~hi_q;
                            if (hi_q)
                                stash_q <= sh_q;
                            else
                            begin
                                o_wr_v <= 1'b1;
                                o_wr <= '{addr: ptr_q, data: {stash_q, sh_q}};
                                ptr_q <= ptr_q + scrc_pkg::PTR_STEP;
                            end
                        end
                        scrc_pkg::ST_IDLE, scrc_pkg::ST_RD:
                        begin
                        end
                    endcase
                end
                if (ack_end)
                begin
                    ack_q <= 1'b0;
                    if (st_q == scrc_pkg::ST_RD)
                    begin
                        // A master that refuses a byte ends the read.
                        if (nack_q)
                            st_q <= scrc_pkg::ST_IDLE;
                        else
                        begin
                            hi_q <= ~hi_q;
                            if (~hi_q)
                                tx_q <= i_rd_data;
                        end
                    end
                end
            end
        end
    end
endmodule

//--- dv/scrc_core_sva.sv
// Purpose: Port timing checks for the sensor-core control block.
// Assumes: One clock domain; synchronous active-high reset.
// Notes: Latency windows allow one to three register stages per output.
`timescale 1ns/100ps
module scrc_core_sva #(
    parameter int ROW_W = 16
) (
    input wire logic i_clk_sys,
    input wire logic i_sys_rst,
    input wire logic i_standby_pin,
    input wire logic i_frame_start,
    input wire logic i_geom_change,
    input wire logic i_dual_adc,
    input wire logic [ROW_W-1:0] i_row_time,
    input wire logic [scrc_pkg::SHDLY_W:0] o_integ_cut_half,
    input wire logic o_sda_oe,
    input wire logic o_no_image,
    input wire logic o_sync_update,
    input wire logic o_frame_out_en,
    input wire logic o_frame_bad,
    input wire logic o_restart,
    input wire logic o_proc_rst,
    input wire logic o_low_power,
    input wire logic o_pix_oe,
    input wire logic o_addr_alt
);
    default clocking dc @(posedge i_clk_sys);
    endclocking
    default disable iff (i_sys_rst);
    logic pend_q;
    always_ff @(posedge i_clk_sys)
    begin
        if (i_sys_rst)
            pend_q <= 1'b0;
        else if (i_geom_change)
            pend_q <= 1'b1;
        else if (i_frame_start)
            pend_q <= 1'b0;
    end
    a_sync_upd_cause: assert property (o_sync_update |-> $past(i_frame_start))
        else $error("sync update without frame start");
    a_cut_cause: assert property ($changed(o_integ_cut_half) |-> $past(i_frame_start)
        || $past(i_frame_start, 2) || $past(i_dual_adc) != $past(i_dual_adc, 2)
        || $past(i_dual_adc, 2) != $past(i_dual_adc, 3))
        else $error("integration cut moved outside a frame start");
    a_noimg_calc: assert property (($stable(i_row_time) && $stable(o_integ_cut_half)) [*3]
        |-> o_no_image == (o_integ_cut_half > {i_row_time, 1'b0}))
        else $error("no image flag disagrees with delay and row time");
    a_outen_noimg: assert property (o_no_image [*2] |-> !o_frame_out_en)
        else $error("frame output enabled without an image");
    a_bad_rise: assert property ($rose(o_frame_bad) |-> $past(i_frame_start) || $past(i_frame_start, 2))
        else $error("bad frame flag rose away from frame start");
    a_bad_after_chg: assert property (i_frame_start && pend_q && !i_geom_change |-> ##[1:2] o_frame_bad)
        else $error("frame after a change not marked bad");
    a_restart_pulse: assert property (o_restart |=> !o_restart)
        else $error("restart longer than one cycle");
    a_pix_oe_up: assert property ($fell(i_sys_rst) && !i_standby_pin && !$past(i_standby_pin)
        |-> ##[1:3] o_pix_oe)
        else $error("pixel pins not driven after reset");
    a_rst_zero: assert property (disable iff (1'b0) i_sys_rst |=> !o_sda_oe && !o_proc_rst
        && !o_low_power && !o_addr_alt && !o_restart && !o_pix_oe)
        else $error("output not cleared by reset");
endmodule
bind scrc_core scrc_core_sva #(.ROW_W(ROW_W)) i_scrc_core_sva (.i_clk_sys(i_clk_sys),
    .i_sys_rst(i_sys_rst), .i_standby_pin(i_standby_pin), .i_frame_start(i_frame_start),
    .i_geom_change(i_geom_change), .i_dual_adc(i_dual_adc), .i_row_time(i_row_time),
    .o_integ_cut_half(o_integ_cut_half), .o_sda_oe(o_sda_oe), .o_no_image(o_no_image),
    .o_sync_update(o_sync_update), .o_frame_out_en(o_frame_out_en), .o_frame_bad(o_frame_bad),
    .o_restart(o_restart), .o_proc_rst(o_proc_rst), .o_low_power(o_low_power),
    .o_pix_oe(o_pix_oe), .o_addr_alt(o_addr_alt));

//--- dv/scrc_core_tb.sv
// Purpose: Self-checking bench for the sensor-core control registers.
// Assumes: Host model on the bus; frame strobes are driven here.
// Notes: Read words are matched against a queue of expected values.
`timescale 1ns/100ps
module scrc_core_tb;
    logic clk = 1'b0;
    logic rst, fs, gc, dual, pin, scl, h_oe, d_oe, rd_v, ni, su, oen, bad, rs, pr, lp, poe, alt, ok;
    logic [15:0] rt, rd_val, n, m;
    logic [14:0] cut;
    logic [7:0] sa;
    wire sda = ~(h_oe | d_oe);
    int bad_count = 0, n_checks = 0, cyc = 0, rs_n = 0, su_n = 0, k, seed = 93;
    string nm_q[$];
    logic [15:0] ex_q[$];
    always #2 clk = ~clk;
    scrc_core #(.ROW_W(16)) i_scrc_core (.i_clk_sys(clk), .i_sys_rst(rst), .i_scl(scl),
        .i_sda(sda), .o_sda_out(), .o_sda_oe(d_oe), .i_standby_pin(pin), .i_frame_start(fs),
        .i_geom_change(gc), .i_dual_adc(dual), .i_row_time(rt), .o_integ_cut_half(cut),
        .o_no_image(ni), .o_sync_update(su), .o_frame_out_en(oen), .o_frame_bad(bad),
        .o_restart(rs), .o_proc_rst(pr), .o_low_power(lp), .o_pix_oe(poe), .o_addr_alt(alt));
    scrc_host i_scrc_host (.i_clk_sys(clk), .i_sda(sda), .o_scl(scl), .o_sda_oe(h_oe),
        .o_rd_v(rd_v), .o_rd_val(rd_val));
    function automatic logic [15:0] x1(input logic v);
        return {15'h0000, v};
    endfunction
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
        n_checks++;
        if (s !== e)
        begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic wrc(input logic [7:0] ra, input logic [15:0] d);
        logic a;
        i_scrc_host.wr(sa, ra, d, a);
        chk("wr_ack", 16'h0001, x1(a));
        repeat (4) @(posedge clk);
    endtask
    task automatic rdx(input string nm, input logic [7:0] ra, input logic [15:0] e);
        logic a;
        nm_q.push_back(nm);
        ex_q.push_back(e);
        i_scrc_host.rd(sa, ra, a);
        chk("rd_ack", 16'h0001, x1(a));
    endtask
    task automatic pulse(input logic g);
        @(posedge clk);
        gc <= g;
        fs <= !g;
        @(posedge clk);
        gc <= 1'b0;
        fs <= 1'b0;
        repeat (3) @(posedge clk);
    endtask
    // A bus read takes about 1.3k clocks and a write about 1.0k; the ceiling leaves ample margin.
    always @(posedge clk)
    begin
        cyc++;
        if (rs === 1'b1)
            rs_n++;
        if (su === 1'b1)
            su_n++;
        if (rd_v === 1'b1)
            chk(nm_q.pop_front(), ex_q.pop_front(), rd_val);
        if (cyc == 60000)
        begin
            bad_count++;
            wrap_up();
        end
    end
    initial
    begin
        rst = 1'b1;
        fs = 1'b0;
        gc = 1'b0;
        dual = 1'b0;
        pin = 1'b0;
        rt = 16'hFFFF;
        sa = 8'hBA;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        rdx("shdly_rst", 8'h0C, 16'h0000);
        rdx("ctrl_rst", 8'h0D, 16'h0000);
        chk("pix_oe_rst", 16'h0001, x1(poe));
        $display("test reset done");
        n = 16'($random(seed)) & 16'h3FFF | 16'h0001;
        wrc(8'h0C, n);
        rdx("shdly_rd", 8'h0C, n);
        chk("cut_pend", 16'h0000, {1'b0, cut});
        pulse(1'b0);
        chk("cut_single", n, {1'b0, cut});
        dual <= 1'b1;
        repeat (3) @(posedge clk);
        chk("cut_dual", n << 1, {1'b0, cut});
        wrc(8'h0D, 16'h8000);
        m = 16'($random(seed)) & 16'h3FFF | 16'h0002;
        wrc(8'h0C, m);
        k = su_n;
        pulse(1'b0);
        chk("cut_hold", n << 1, {1'b0, cut});
        chk("upd_hold", 16'h0000, 16'(su_n - k));
        rdx("ctrl_hold", 8'h0D, 16'h8000);
        wrc(8'h0D, 16'h0000);
        chk("cut_held", n << 1, {1'b0, cut});
        pulse(1'b0);
        chk("cut_rel", m << 1, {1'b0, cut});
        chk("upd_rel", 16'h0001, 16'(su_n - k));
        rt <= m;
        repeat (4) @(posedge clk);
        chk("image_edge", 16'h0000, x1(ni));
        rt <= m - 16'h0001;
        repeat (4) @(posedge clk);
        chk("no_image", 16'h0001, x1(ni));
        chk("out_en_noimg", 16'h0000, x1(oen));
        rt <= 16'hFFFF;
        $display("test shutter done");
        pulse(1'b1);
        pulse(1'b0);
        chk("bad", 16'h0001, x1(bad));
        chk("out_en_bad", 16'h0000, x1(oen));
        wrc(8'h0D, 16'h0100);
        chk("out_en_show", 16'h0001, x1(oen));
        pulse(1'b0);
        chk("good", 16'h0000, x1(bad));
        k = rs_n;
        pulse(1'b1);
        pulse(1'b0);
        chk("no_restart", 16'h0000, 16'(rs_n - k));
        wrc(8'h0D, 16'h0200);
        pulse(1'b1);
        pulse(1'b0);
        chk("restart_bad", 16'h0001, 16'(rs_n - k));
        wrc(8'h0D, 16'h0002);
        chk("restart_wr", 16'h0002, 16'(rs_n - k));
        rdx("ctrl_restart", 8'h0D, 16'h0000);
        $display("test frames done");
        wrc(8'h0D, 16'h0020);
        chk("proc_rst_on", 16'h0001, x1(pr));
        wrc(8'h0D, 16'h0004);
        chk("proc_rst_off", 16'h0000, x1(pr));
        chk("low_power", 16'h0001, x1(lp));
        wrc(8'h0D, 16'h0010);
        chk("oe_bit4", 16'h0001, x1(poe));
        wrc(8'h0D, 16'h0050);
        chk("oe_bit4_6", 16'h0000, x1(poe));
        pin <= 1'b1;
        for (int c = 0; c < 4; c++)
        begin
            wrc(8'h0D, 16'(c << 6));
            chk("pin_lp", x1(c < 2), x1(lp));
            chk("pin_oe", x1(c == 3), x1(poe));
        end
        wrc(8'h0D, 16'h0400);
        chk("alt_standby", 16'h0000, x1(alt));
        pin <= 1'b0;
        wrc(8'h0D, 16'h0400);
        chk("alt_set", 16'h0001, x1(alt));
        sa = 8'h90;
        rdx("ctrl_alt", 8'h0D, 16'h0400);
        i_scrc_host.rd(8'hBA, 8'h0D, ok);
        chk("old_addr", 16'h0000, x1(ok));
        wrc(8'h0D, 16'h0000);
        sa = 8'hBA;
        rdx("ctrl_dflt", 8'h0D, 16'h0000);
        rdx("unmapped", 8'h20, 16'h0000);
        $display("test address done");
        wrap_up();
    end
endmodule

//--- dv/scrc_host.sv
// Purpose: Host controller model on the two-wire register bus.
// Assumes: SDA has a pull-up; the device never holds SCL low.
// Notes: Each phase lasts Q+1 clocks so the device's synchronisers keep up.
`timescale 1ns/100ps
module scrc_host (
    input wire logic i_clk_sys,
    input wire logic i_sda,
    output logic o_scl,
    output logic o_sda_oe,
    output logic o_rd_v,
    output logic [15:0] o_rd_val
);
    localparam int Q = 8;
    initial
    begin
        o_scl = 1'b1;
        o_sda_oe = 1'b0;
        o_rd_v = 1'b0;
        o_rd_val = 16'h0000;
    end
    task automatic ph(input logic c, input logic oe);
        @(posedge i_clk_sys);
        o_scl <= c;
        o_sda_oe <= oe;
        repeat (Q) @(posedge i_clk_sys);
    endtask
    task automatic start();
        ph(1'b0, 1'b0);
        ph(1'b1, 1'b0);
        ph(1'b1, 1'b1);
        ph(1'b0, 1'b1);
    endtask
    task automatic stop();
        ph(1'b0, 1'b1);
        ph(1'b1, 1'b1);
        ph(1'b1, 1'b0);
    endtask
    // SDA changes only while SCL is low, a full phase away from either edge.
    task automatic bx(input logic [8:0] v, output logic [8:0] r);
        for (int i = 8; i >= 0; i--)
        begin
            ph(1'b0, !v[i]);
            ph(1'b1, !v[i]);
            r[i] = i_sda;
            ph(1'b0, !v[i]);
        end
    endtask
    // Only sensor-core registers are addressed, never processor pages.
    task automatic wr(input logic [7:0] sa, ra, input logic [15:0] d, output logic ok);
        logic [8:0] r0, r1, r2, r3;
        logic [15:0] w;
        w = d;
        ok = 1'b0;
        if (ra >= 8'hF7 && ra <= 8'hFD) return;
        if (ra == scrc_pkg::REG_CORE_RESET_CONTROL) w[3] = 1'b0;
        start();
        bx({sa, 1'b1}, r0);
        bx({ra, 1'b1}, r1);
        bx({w[15:8], 1'b1}, r2);
        bx({w[7:0], 1'b1}, r3);
        stop();
        ok = !(r0[0] | r1[0] | r2[0] | r3[0]);
    endtask
    task automatic rd(input logic [7:0] sa, ra, output logic ok);
        logic [8:0] r0, r1, r2, h, l;
        start();
        bx({sa, 1'b1}, r0);
        bx({ra, 1'b1}, r1);
        start();
        bx({sa | 8'h01, 1'b1}, r2);
        bx({8'hFF, 1'b0}, h);
        bx(9'h1FF, l);
        stop();
        ok = !(r0[0] | r1[0] | r2[0]);
        @(posedge i_clk_sys);
        o_rd_val <= {h[8:1], l[8:1]};
        o_rd_v <= ok;
        @(posedge i_clk_sys);
        o_rd_v <= 1'b0;
    endtask
endmodule

//--- include/scrc_pkg.sv
// Purpose: Shared constants and types of the sensor-core control registers.
// Assumes: Register addresses are the 8-bit indices carried on the serial bus.
// Notes: Slave addresses are held as 7-bit values, the R/W bit excluded.
package scrc_pkg;
    localparam logic [7:0] REG_SHUTTER_DELAY = 8'h0C;
    localparam logic [7:0] REG_CORE_RESET_CONTROL = 8'h0D;
    localparam logic [15:0] RESET_VALUE = 16'h0000;
    localparam logic [15:0] READ_ZERO = 16'h0000;
    localparam int SHDLY_W = 14;
    localparam logic [6:0] SADDR_DEFAULT = 7'h5D;
    localparam logic [6:0] SADDR_ALT = 7'h48;
    localparam int BIT_HOLD = 15;
    localparam int BIT_SADDR_SEL = 10;
    localparam int BIT_RESTART_BAD = 9;
    localparam int BIT_SHOW_BAD = 8;
    localparam int POL_HI = 7;
    localparam int POL_LO = 6;
    localparam int BIT_PROC_RST = 5;
    localparam int BIT_OUT_DIS = 4;
    localparam int BIT_STANDBY = 2;
    localparam int BIT_RESTART = 1;
    localparam logic [15:0] CTRL_STORE_MASK = 16'h87FC;
    localparam logic [1:0] POL_PIN_TRI = 2'h2;
    localparam logic [3:0] BIT_LAST = 4'h7;
    localparam logic [3:0] CNT_ZERO = 4'h0;
    localparam logic [3:0] CNT_STEP = 4'h1;
    localparam logic [7:0] PTR_STEP = 8'h01;
    typedef struct packed {
        logic [7:0] addr;
        logic [15:0] data;
    } scrc_wr_s;
    typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_REG, ST_WR, ST_RD} scrc_tw_e;
endpackage
